//--- wdr_watchdog.sv
// Watchdog with reset output: 14-bit supervision counter, key service
// register, auxiliary control bits and the reset pin driver.
// Assumes clk is the oscillator; power-down and idle come from the core
// on this clock; the reset pin and wake interrupt pin are asynchronous.
//
// Behaviour
// - A 14-bit counter, disabled after leaving reset until software enables it.
// - Writing 1E then E1 to the service register enables counting.
// - Once enabled, the counter advances one step every machine cycle.
// - No software disable; only hardware reset or overflow disables it.
// - While enabled, each 1E then E1 pair clears the counter.
// - Reaching 3FFF overflows and resets the whole device.
// - Overflow drives the reset pin high for 98 oscillator periods.
// - Service register is write-only; counter is not software visible.
// - Counting stops in power-down; no servicing needed there.
// - Power-down ends on hardware reset or an enabled low wake interrupt.
// - After interrupt wake, counting waits until the interrupt line goes high.
// - Idle-halt bit 4 at zero keeps counting through idle.
// - Idle-halt bit set freezes the count in idle, resuming afterwards.
// - Reset-out disable bit 3: zero drives pin, one leaves pin input only.
// - A machine cycle is 12 oscillator periods.
// - External high on reset pin for two machine cycles resets device, except in power-down.
// - Reset-output feature is enabled after reset.
`timescale 1ns/1ps

module wdr_watchdog #(
  parameter int COUNTER_WIDTH = wdr_pkg::COUNT_WIDTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  input wire logic idle_mode,
  input wire logic power_down,
  input wire logic wake_int_enabled,
  input wire logic wake_int_n,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic device_reset,
  output logic power_down_wake,
  output logic watchdog_enabled,
  output logic ale_disable
);
  import wdr_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [COUNTER_WIDTH-1:0] supervision_counter;

  // Counter end points; a narrower counter keeps the all-ones limit
  localparam logic [COUNTER_WIDTH-1:0] CNT_ZERO = COUNTER_WIDTH'(COUNT_RESET);
  localparam logic [COUNTER_WIDTH-1:0] CNT_LIMIT = COUNTER_WIDTH'(COUNT_LIMIT);
  logic [3:0] machine_phase;
  logic machine_tick;
  logic [7:0] auxiliary_control;
  logic wake_sync1;
  logic wake_low;
  logic pin_sync1;
  logic pin_high;
  logic [4:0] ext_high_count;
  logic ext_reset_active;
  logic wake_hold;
  logic count_halt;
  logic overflow;
  logic pulse_busy;
  logic drive_pin;
  logic clear_all;
  logic svc_write;

  wdr_key_if key_bus ();

  // Local clear: power-on reset or any device reset in progress
  assign clear_all = rst | device_reset;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Wake interrupt pin, two flops, stored as a low level
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_sync1 <= 1'b1;
      wake_low <= 1'b0;
    end else begin
      wake_sync1 <= wake_int_n;
      wake_low <= ~wake_sync1;
    end
  end

  // Reset pin, two flops
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_sync1 <= 1'b0;
      pin_high <= 1'b0;
    end else begin
      pin_sync1 <= reset_pin_in;
      pin_high <= pin_sync1;
    end
  end

  // ****************************************************************
  // Machine cycle timing
  // ****************************************************************

  // Divide the oscillator by twelve into machine-cycle ticks
  always_ff @(posedge clk) begin
    if (clear_all) begin
      machine_phase <= 4'h0;
    end else if (machine_tick) begin
      machine_phase <= 4'h0;
    end else begin
      machine_phase <= machine_phase + 4'h1;
    end
  end

  assign machine_tick = (machine_phase == 4'(MACHINE_CYCLES - 1));

  // ****************************************************************
  // Register access
  // ****************************************************************

  // Auxiliary control: only bits 0, 3 and 4 hold state
  always_ff @(posedge clk) begin
    if (clear_all) begin
      auxiliary_control <= AUX_RESET;
    end else if (sfr_wr && sfr_addr == ADDR_AUXILIARY_CONTROL) begin
      auxiliary_control <= sfr_wdata & AUX_WRITABLE;
    end
  end

  // Read answer one cycle after the strobe; service register reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      sfr_rvalid <= 1'b0;
    end else begin
      sfr_rvalid <= sfr_rd;
      if (sfr_rd && sfr_addr == ADDR_AUXILIARY_CONTROL) begin
        sfr_rdata <= auxiliary_control;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // ALE disable bit mirrored for the bus logic
  always_ff @(posedge clk) begin
    if (rst) begin
      ale_disable <= 1'b0;
    end else begin
      ale_disable <= auxiliary_control[BIT_ALE_DISABLE];
    end
  end

  // ****************************************************************
  // Key sequence detection
  // ****************************************************************

  // Only writes to the service address reach the detector
  assign svc_write = sfr_wr && (sfr_addr == ADDR_WATCHDOG_SERVICE);
  assign key_bus.wr = svc_write;
  assign key_bus.data = sfr_wdata;

  wdr_key_detect u_key (
    .clk(clk),
    .rst(rst),
    .clear(device_reset),
    .key(key_bus)
  );

  // ****************************************************************
  // Enable and halt control
  // ****************************************************************

  // One-time enable, cleared only by power-on reset or a device reset
  always_ff @(posedge clk) begin
    if (clear_all) begin
      watchdog_enabled <= 1'b0;
    end else if (key_bus.hit) begin
      watchdog_enabled <= 1'b1;
    end
  end

  // Hold after power-down until the wake line is high again
  always_ff @(posedge clk) begin
    if (clear_all) begin
      wake_hold <= 1'b0;
    end else if (power_down) begin
      wake_hold <= 1'b1;
    end else if (!wake_low) begin
      wake_hold <= 1'b0;
    end
  end

  // Wake request while powered down and the level interrupt is enabled
  always_ff @(posedge clk) begin
    if (clear_all) begin
      power_down_wake <= 1'b0;
    end else begin
      power_down_wake <= power_down && wake_int_enabled && wake_low;
    end
  end

  // Stop in power-down, while waiting for the wake line, or in idle if chosen
  assign count_halt = power_down
    | wake_hold
    | (idle_mode & auxiliary_control[BIT_IDLE_HALT_SELECT]);

  // ****************************************************************
  // Supervision counter
  // ****************************************************************

  // Overflow once the count has reached the limit
  assign overflow = watchdog_enabled && (supervision_counter == CNT_LIMIT);

  // Advance per machine cycle; a key pair or a reset clears it
  always_ff @(posedge clk) begin
    if (clear_all) begin
      supervision_counter <= CNT_ZERO;
    end else if (key_bus.hit) begin
      supervision_counter <= CNT_ZERO;
    end else if (overflow) begin
      supervision_counter <= CNT_ZERO;
    end else if (watchdog_enabled && machine_tick && !count_halt) begin
      supervision_counter <= supervision_counter + 1'b1;
    end
  end

  // ****************************************************************
  // External reset detection
  // ****************************************************************

  // Count consecutive high samples of the pin while not driving it
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_high_count <= 5'h00;
      ext_reset_active <= 1'b0;
    end else if (!pin_high || drive_pin || power_down) begin
      ext_high_count <= 5'h00;
      ext_reset_active <= 1'b0;
    end else if (ext_high_count == 5'(EXT_RESET_CYCLES - 1)) begin
      ext_reset_active <= 1'b1;
    end else begin
      ext_high_count <= ext_high_count + 5'h01;
    end
  end

  // ****************************************************************
  // Reset pulse and pin driver
  // ****************************************************************

  wdr_pulse #(
    .LENGTH(RESET_PULSE_CYCLES)
  ) u_pulse (
    .clk(clk),
    .rst(rst),
    .start(overflow),
    .busy(pulse_busy)
  );

  // Pin drive decision latched at overflow
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_pin <= 1'b0;
    end else if (overflow) begin
      drive_pin <= ~auxiliary_control[BIT_RESET_OUT_DISABLE];
    end else if (!pulse_busy) begin
      drive_pin <= 1'b0;
    end
  end

  // Drive the reset pin high for the pulse length
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b0;
    end else begin
      reset_pin_out <= pulse_busy & drive_pin;
      reset_pin_oe <= pulse_busy & drive_pin;
    end
  end

  // Device reset covers overflow pulse and external reset
  always_ff @(posedge clk) begin
    if (rst) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= overflow | pulse_busy | ext_reset_active;
    end
  end

endmodule : wdr_watchdog

//--- wdr_pkg.sv
// Constants shared by the watchdog with reset output and its helpers.
// Assumes one clock that is the oscillator itself, one count per period.
package wdr_pkg;

  // ****************************************************************
  // Special function register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_AUXILIARY_CONTROL = 8'h8e;
  localparam logic [7:0] ADDR_WATCHDOG_SERVICE = 8'ha6;

  // ****************************************************************
  // Field positions and values after reset
  // ****************************************************************
  localparam int BIT_ALE_DISABLE = 0;
  localparam int BIT_RESET_OUT_DISABLE = 3;
  localparam int BIT_IDLE_HALT_SELECT = 4;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] AUX_WRITABLE = 8'h19;

  // ****************************************************************
  // Key bytes of the service sequence
  // ****************************************************************
  localparam logic [7:0] KEY_FIRST = 8'h1e;
  localparam logic [7:0] KEY_SECOND = 8'he1;

  // ****************************************************************
  // Counter and timing
  // ****************************************************************
  localparam int COUNT_WIDTH = 14;
  localparam logic [13:0] COUNT_RESET = 14'h0000;
  localparam logic [13:0] COUNT_LIMIT = 14'h3fff;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int OSC_PERIOD_PS = 25000;
  localparam int MACHINE_OSC_PERIODS = 12;
  localparam int MACHINE_CYCLES = (MACHINE_OSC_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_PULSE_OSC_PERIODS = 98;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_OSC_PERIODS * OSC_PERIOD_PS) / CLK_PERIOD_PS;
  localparam int EXT_RESET_MACHINE_CYCLES = 2;
  localparam int EXT_RESET_CYCLES = EXT_RESET_MACHINE_CYCLES * MACHINE_CYCLES;

  // ****************************************************************
  // Key detector states
  // ****************************************************************
  typedef enum logic [0:0] {
    KEY_WAIT_FIRST = 1'b0,
    KEY_WAIT_SECOND = 1'b1
  } wdr_key_state_t;

endpackage : wdr_pkg

//--- wdr_key_if.sv
// Interface carrying service-register writes to the key detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface wdr_key_if;
  logic wr;
  logic [7:0] data;
  logic hit;

  // Detector takes writes and reports a completed key pair
  modport det (input wr, input data, output hit);
  // Owner issues writes and watches for the pair
  modport user (output wr, output data, input hit);
endinterface : wdr_key_if

//--- wdr_key_detect.sv
// Key-sequence detector for the watchdog service register.
// Assumes writes arrive as one-cycle strobes on the system clock.
`timescale 1ns/1ps

module wdr_key_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  wdr_key_if.det key
);
  import wdr_pkg::*;

  wdr_key_state_t state;
  wdr_key_state_t next_state;
  logic next_hit;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_hit = 1'b0;
    if (key.wr) begin
      case (state)
        KEY_WAIT_FIRST: begin
          if (key.data == KEY_FIRST) begin
            next_state = KEY_WAIT_SECOND;
          end
        end
        KEY_WAIT_SECOND: begin
          if (key.data == KEY_SECOND) begin
            next_hit = 1'b1;
            next_state = KEY_WAIT_FIRST;
          end else if (key.data == KEY_FIRST) begin
            next_state = KEY_WAIT_SECOND;
          end else begin
            next_state = KEY_WAIT_FIRST;
          end
        end
        default: begin
          next_state = KEY_WAIT_FIRST;
        end
      endcase
    end
  end

  // State and hit pulse registers
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      state <= KEY_WAIT_FIRST;
      key.hit <= 1'b0;
    end else begin
      state <= next_state;
      key.hit <= next_hit;
    end
  end

endmodule : wdr_key_detect

//--- wdr_pulse.sv
// Fixed-length pulse generator for the reset output.
// Assumes start is a one-cycle strobe; a start while busy is ignored.
`timescale 1ns/1ps

module wdr_pulse #(
  parameter int LENGTH = 98
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic busy
);
  import wdr_pkg::*;

  localparam int CW = $clog2(LENGTH + 1);
  localparam logic [CW-1:0] LAST = CW'(LENGTH - 1);

  logic [CW-1:0] count;

  // Count out the pulse length, one cycle per oscillator period
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      count <= '0;
    end else if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        count <= '0;
      end
    end else if (count == LAST) begin
      busy <= 1'b0;
    end else begin
      count <= count + 1'b1;
    end
  end

endmodule : wdr_pulse

//--- wdr_watchdog_props.sv
// Checker for the watchdog with reset output, on its top ports.
// Assumes one clock and a synchronous active-high rst.
`timescale 1ns/1ps

module wdr_watchdog_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic power_down,
  input wire logic wake_int_enabled,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic device_reset,
  input wire logic power_down_wake,
  input wire logic watchdog_enabled,
  input wire logic ale_disable
);
  // ****************
  // Helper counters
  // ****************
  logic [6:0] oe_cnt;
  logic [5:0] pin_cnt;

  // Length of the current pin drive
  always_ff @(posedge clk) begin
    if (rst || !reset_pin_oe) begin
      oe_cnt <= 7'h00;
    end else begin
      oe_cnt <= oe_cnt + 7'h01;
    end
  end

  // Run of external high on the reset pin, saturating
  always_ff @(posedge clk) begin
    if (rst || !reset_pin_in || reset_pin_oe || power_down) begin
      pin_cnt <= 6'h00;
    end else if (pin_cnt != 6'h3f) begin
      pin_cnt <= pin_cnt + 6'h01;
    end
  end

  // ****************
  // Properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence key_first_s;
    sfr_wr && sfr_addr == 8'ha6 && sfr_wdata == 8'h1e && !device_reset;
  endsequence
  sequence key_second_s;
    sfr_wr && sfr_addr == 8'ha6 && sfr_wdata == 8'he1 && !device_reset;
  endsequence

  key_enable_a: assert property (key_first_s ##1 !sfr_wr ##1 key_second_s |-> ##2 (watchdog_enabled || device_reset))
    else $error("key pair did not enable the watchdog");
  no_swdisable_a: assert property ($fell(watchdog_enabled) |-> device_reset || $past(device_reset))
    else $error("watchdog disabled without a reset");
  enable_drop_a: assert property (device_reset [*2] |-> !watchdog_enabled)
    else $error("watchdog still enabled during reset");
  pin_drive_a: assert property (reset_pin_oe |-> reset_pin_out && device_reset)
    else $error("pin drive without high level or reset");
  pin_start_a: assert property ($rose(reset_pin_oe) |-> $past(device_reset))
    else $error("pin drive started without reset");
  pulse_len_a: assert property ($fell(reset_pin_oe) |-> oe_cnt == 7'h62)
    else $error("reset pulse length wrong");
  unmapped_read_a: assert property (sfr_rd && sfr_addr != 8'h8e |=> sfr_rdata == 8'h00)
    else $error("service or unmapped read not zero");
  wake_flag_a: assert property (power_down_wake |-> $past(power_down) && $past(wake_int_enabled))
    else $error("wake flag outside enabled power-down");
  ext_reset_a: assert property (pin_cnt == 6'h1e |-> device_reset)
    else $error("long external reset not taken");
  ale_mirror_a: assert property (sfr_wr && sfr_addr == 8'h8e && !device_reset
    |-> ##2 (ale_disable == $past(sfr_wdata[0], 2) || device_reset))
    else $error("ale disable bit not mirrored");
endmodule : wdr_watchdog_props

bind wdr_watchdog wdr_watchdog_props chk (.clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .power_down(power_down),
  .wake_int_enabled(wake_int_enabled), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
  .reset_pin_oe(reset_pin_oe), .device_reset(device_reset), .power_down_wake(power_down_wake),
  .watchdog_enabled(watchdog_enabled), .ale_disable(ale_disable));

//--- wdr_watchdog_tb.sv
// Self-checking bench for the watchdog with reset output.
// Assumes the checker is bound from its own file; two overflow runs on a narrowed counter.
`timescale 1ns/1ps

module wdr_watchdog_tb;
  import wdr_pkg::*;
  // Narrow counter keeps each overflow run short; halts in the first run total 3000 cycles
  localparam int TB_COUNT_WIDTH = 10;
  localparam int HALT_CYCLES = 3000;
  localparam int OVF_EXPECT = ((1 << TB_COUNT_WIDTH) - 1) * MACHINE_CYCLES + HALT_CYCLES;
  logic clk, rst, sfr_wr, sfr_rd, idle_mode, power_down, wake_int_enabled, wake_int_n, ext_rst;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val;
  logic sfr_rvalid, reset_pin_out, reset_pin_oe, device_reset, power_down_wake, watchdog_enabled, ale_disable;
  wire logic reset_pin_in;
  int num_errors, total_checks, t0, n_dr, n_oe;
  int ncyc = 0;
  // Address, write data, expected read back
  logic [23:0] rows [7] = '{24'h8eff19, 24'h8e1010, 24'h8e0808, 24'h8e0101, 24'h8e0000, 24'ha60000, 24'h55ff00};

  // Pin level: our drive wins, else the external source
  assign reset_pin_in = reset_pin_oe ? reset_pin_out : ext_rst;

  wdr_watchdog #(.COUNTER_WIDTH(TB_COUNT_WIDTH)) dut (.clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .idle_mode(idle_mode),
    .power_down(power_down), .wake_int_enabled(wake_int_enabled), .wake_int_n(wake_int_n),
    .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .device_reset(device_reset), .power_down_wake(power_down_wake),
    .watchdog_enabled(watchdog_enabled), .ale_disable(ale_disable));

  // Clock and cycle count
  always #12.5 clk = ~clk;
  always @(posedge clk) ncyc <= ncyc + 1;

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk({7'h00, sfr_rvalid}, 8'h01);
    rd_val = sfr_rdata;
  endtask : rd

  task automatic key();
    wr(8'ha6, 8'h1e);
    wr(8'ha6, 8'he1);
    cyc(4);
  endtask : key

  // Length of the device reset and of the driven pin high
  task automatic pulse_count();
    n_dr = 0;
    n_oe = 0;
    while (device_reset && n_dr < 200) begin
      n_dr++;
      n_oe = n_oe + int'(reset_pin_oe & reset_pin_out);
      @(negedge clk);
    end
  endtask : pulse_count

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // Hang guard
  initial begin
    repeat (50000) @(posedge clk);
    $display("Error at %0t: run did not finish", $time);
    num_errors++;
    final_report();
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    {clk, sfr_wr, sfr_rd, idle_mode, power_down, wake_int_enabled, ext_rst} = 7'h00;
    {sfr_addr, sfr_wdata} = 16'h0000;
    {rst, wake_int_n} = 2'h3;
    num_errors = 0;
    total_checks = 0;
    cyc(3);
    rst = 1'b0;
    rd(8'h8e);
    chk(rd_val, 8'h00);
    chk({4'h0, device_reset, reset_pin_oe, watchdog_enabled, ale_disable}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk(rd_val, rows[i][7:0]);
    end
    $display("test registers done");
    // Broken pair, then a good pair with another address between
    wr(8'ha6, 8'h1e);
    wr(8'ha6, 8'h55);
    wr(8'ha6, 8'he1);
    cyc(4);
    chk({7'h00, watchdog_enabled}, 8'h00);
    wr(8'ha6, 8'h1e);
    wr(8'h8e, 8'h00);
    wr(8'ha6, 8'he1);
    cyc(4);
    chk({7'h00, watchdog_enabled}, 8'h01);
    wr(8'ha6, 8'h00);
    wr(8'h8e, 8'h00);
    cyc(50);
    chk({7'h00, watchdog_enabled}, 8'h01);
    // Short external pulse is ignored, long one resets
    ext_rst = 1'b1;
    cyc(10);
    ext_rst = 1'b0;
    cyc(4);
    chk({6'h00, device_reset, watchdog_enabled}, 8'h01);
    ext_rst = 1'b1;
    cyc(40);
    chk({7'h00, device_reset}, 8'h01);
    ext_rst = 1'b0;
    cyc(6);
    chk({6'h00, device_reset, watchdog_enabled}, 8'h00);
    $display("test key and pin done");
    // Enable, service later, then halts that stretch the timeout
    key();
    cyc(6000);
    key();
    t0 = ncyc;
    wr(8'h8e, 8'h10);
    idle_mode = 1'b1;
    cyc(1200);
    idle_mode = 1'b0;
    wr(8'h8e, 8'h00);
    idle_mode = 1'b1;
    cyc(1200);
    idle_mode = 1'b0;
    wake_int_enabled = 1'b1;
    wake_int_n = 1'b0;
    power_down = 1'b1;
    cyc(1200);
    chk({7'h00, power_down_wake}, 8'h01);
    power_down = 1'b0;
    cyc(600);
    wake_int_n = 1'b1;
    while (!device_reset && ncyc - t0 < OVF_EXPECT + 1000) @(negedge clk);
    chk({7'h00, (ncyc - t0 >= OVF_EXPECT - 50 && ncyc - t0 <= OVF_EXPECT + 50)}, 8'h01);
    pulse_count();
    chk(n_dr[7:0], 8'h63);
    chk(n_oe[7:0], 8'h62);
    chk({7'h00, watchdog_enabled}, 8'h00);
    $display("test overflow done");
    // Pin drive disabled; serviced before power-down, after wake and between idle spells
    wr(8'h8e, 8'h08);
    key();
    power_down = 1'b1;
    cyc(50);
    wake_int_n = 1'b0;
    cyc(50);
    power_down = 1'b0;
    cyc(20);
    wake_int_n = 1'b1;
    cyc(4);
    key();
    idle_mode = 1'b1;
    cyc(600);
    idle_mode = 1'b0;
    key();
    idle_mode = 1'b1;
    cyc(600);
    idle_mode = 1'b0;
    chk({6'h00, device_reset, watchdog_enabled}, 8'h01);
    t0 = ncyc;
    while (!device_reset && ncyc - t0 < OVF_EXPECT) @(negedge clk);
    pulse_count();
    chk(n_dr[7:0], 8'h63);
    chk(n_oe[7:0], 8'h00);
    $display("test pin disable done");
    final_report();
  end
endmodule : wdr_watchdog_tb
